// ### verilog/iecs_core.sv
`timescale 1ns/1ps
module iecs_core (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       clk_en,
	// instruction from program store
	input  wire logic [3:0] instr_op,
	input  wire logic [7:0] instr_arg,
	input  wire logic [3:0] instr_reg,
	input  wire logic       instr_cond_z,
	// link
	iecs_link_if.core       link,
	// status
	output logic            carry_q,
	output logic            zero_q,
	output logic            int_enable_q,
	output logic [7:0]      reg0_q
);
	// ----------------------------------------
	// request synchroniser
	// ----------------------------------------
	logic [2:0] irq_sync_q;
	logic       irq_q;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			irq_sync_q <= 3'h0;
		else if (clk_en)
			irq_sync_q <= {irq_sync_q[1:0], link.interrupt};
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			irq_q <= 1'b0;
		else if (clk_en && irq_sync_q[1] == irq_sync_q[2])
			irq_q <= irq_sync_q[2];
	end

	// ----------------------------------------
	// two-cycle instruction slot
	// ----------------------------------------
	logic       phase_q;
	logic [7:0] pc_q;
	logic [7:0] regs_q [0:15];
	logic       sv_carry_q;
	logic       sv_zero_q;
	logic       take_int;
	logic       push;
	logic       pop;
	logic [7:0] top_data;
	logic [7:0] rd_val;
	logic [7:0] sub_val;
	iecs_pkg::iecs_op_e op;

	assign op      = iecs_pkg::iecs_op_e'(instr_op);
	assign rd_val  = regs_q[instr_reg];
	assign sub_val = 8'(rd_val - instr_arg);

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			phase_q <= 1'b0;
		else if (clk_en)
			phase_q <= ~phase_q;
	end

	assign take_int = phase_q && irq_q && int_enable_q;
	assign push     = phase_q && (take_int || op == iecs_pkg::IECS_OP_CALL);
	assign pop      = phase_q && !take_int
		&& (op == iecs_pkg::IECS_OP_RETURN || op == iecs_pkg::IECS_OP_RETI);

	iecs_stack #(
		.DEPTH (iecs_pkg::STACK_DEPTH)
	) u_stack (
		.clk       (clk),
		.reset_n   (reset_n),
		.clk_en    (clk_en),
		.push      (push),
		.pop       (pop),
		.push_data (take_int ? pc_q : 8'(pc_q + 8'h01)),
		.top_data  (top_data)
	);

	// ----------------------------------------
	// program counter
	// ----------------------------------------
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			pc_q <= iecs_pkg::RESET_ADDR;
		else if (clk_en && phase_q)
		begin
			if (take_int)
				pc_q <= iecs_pkg::VECTOR_ADDR;
			else
				case (op)
					iecs_pkg::IECS_OP_JUMP:
						pc_q <= (!instr_cond_z || zero_q) ? instr_arg : 8'(pc_q + 8'h01);
					iecs_pkg::IECS_OP_CALL:
						pc_q <= instr_arg;
					iecs_pkg::IECS_OP_RETURN,
					iecs_pkg::IECS_OP_RETI:
						pc_q <= top_data;
					default:
						pc_q <= 8'(pc_q + 8'h01);
				endcase
		end
	end

	// ----------------------------------------
	// interrupt enable
	// ----------------------------------------
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			int_enable_q <= 1'b0;
		else if (clk_en && phase_q)
		begin
			if (take_int)
				int_enable_q <= 1'b0;
			else if (op == iecs_pkg::IECS_OP_EINT)
				int_enable_q <= 1'b1;
			else if (op == iecs_pkg::IECS_OP_DINT)
				int_enable_q <= 1'b0;
			else if (op == iecs_pkg::IECS_OP_RETI)
				int_enable_q <= instr_arg[0];
		end
	end

	// ----------------------------------------
	// flags and save
	// ----------------------------------------
	// save completed flags
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sv_carry_q <= 1'b0;
			sv_zero_q  <= 1'b0;
		end
		else if (clk_en && take_int)
		begin
			sv_carry_q <= carry_q;
			sv_zero_q  <= zero_q;
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			carry_q <= 1'b0;
			zero_q  <= 1'b0;
		end
		else if (clk_en && phase_q && !take_int)
			case (op)
				iecs_pkg::IECS_OP_SUB:
				begin
					carry_q <= (instr_arg > rd_val);
					zero_q  <= iecs_pkg::is_zero(sub_val);
				end
				iecs_pkg::IECS_OP_AND:
				begin
					carry_q <= 1'b0;
					zero_q  <= iecs_pkg::is_zero(rd_val & regs_q[instr_arg[3:0]]);
				end
				iecs_pkg::IECS_OP_RETI:
				begin
					carry_q <= sv_carry_q;
					zero_q  <= sv_zero_q;
				end
				default:
				begin
					carry_q <= carry_q;
					zero_q  <= zero_q;
				end
			endcase
	end

	// ----------------------------------------
	// register file
	// ----------------------------------------
	// result written back
	always_ff @(posedge clk)
	begin
		if (clk_en && phase_q && !take_int)
			case (op)
				iecs_pkg::IECS_OP_SUB:
					regs_q[instr_reg] <= sub_val;
				iecs_pkg::IECS_OP_AND:
					regs_q[instr_reg] <= rd_val & regs_q[instr_arg[3:0]];
				iecs_pkg::IECS_OP_LOAD:
					regs_q[instr_reg] <= instr_arg;
				iecs_pkg::IECS_OP_INPUT:
					regs_q[instr_reg] <= link.in_port;
				default:
					regs_q[instr_reg] <= rd_val;
			endcase
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			reg0_q <= 8'h00;
		else if (clk_en)
			reg0_q <= regs_q[0];
	end

	assign link.address      = pc_q;
	assign link.port_id      = instr_arg;
	assign link.write_strobe = phase_q && !take_int && op == iecs_pkg::IECS_OP_OUTPUT;
	assign link.read_strobe  = phase_q && !take_int && op == iecs_pkg::IECS_OP_INPUT;
	assign link.out_port     = rd_val;
endmodule

// ### verilog/iecs_pkg.sv
// How it works
// - accepted interrupt forces address bus to FF
// - fetched instruction at interrupt is abandoned
// - saved flags come from last completed instruction
// - return restores flags, resumes abandoned address
// - every instruction and entry takes two cycles
// - fabric holds request across two rising edges
// - fabric may clear request on port write
// - fabric may clear request on read strobe
// - fabric may clear request seeing address FF
// - stack pushes on call/interrupt, pops on return
// - stack pointer managed purely by hardware
// - stack holds fifteen nested return addresses
// - circular stack, sixteenth push overwrites oldest
// - subtract writes back, sets zero on zero
// - and with itself keeps value, sets zero on zero
// - interrupts disabled after reset until enabled
// - entry pushes pc and saves carry, zero
// - accepting interrupt clears interrupt enable
// - return from interrupt has enable option bit
package iecs_pkg;
	// ----------------------------------------
	// widths and addresses
	// ----------------------------------------
	localparam int       ADDR_W      = 8;
	localparam int       DATA_W      = 8;
	localparam int       STACK_DEPTH = 15;
	localparam int       PTR_W       = 4;
	localparam bit [7:0] VECTOR_ADDR = 8'hFF;
	localparam bit [7:0] RESET_ADDR  = 8'h00;
	localparam bit [7:0] ACK_PORT    = 8'h01;
	localparam bit [7:0] CAUSE_PORT  = 8'h02;

	// ----------------------------------------
	// operation codes
	// ----------------------------------------
	typedef enum logic [3:0] {
		IECS_OP_NOP,
		IECS_OP_JUMP,
		IECS_OP_CALL,
		IECS_OP_RETURN,
		IECS_OP_RETI,
		IECS_OP_EINT,
		IECS_OP_DINT,
		IECS_OP_SUB,
		IECS_OP_AND,
		IECS_OP_LOAD,
		IECS_OP_OUTPUT,
		IECS_OP_INPUT
	} iecs_op_e;

	// ----------------------------------------
	// shared helpers
	// ----------------------------------------
	function automatic logic is_zero(input logic [7:0] v);
		is_zero = (v == 8'h00);
	endfunction
endpackage

// ### verilog/iecs_link_if.sv
`timescale 1ns/1ps
interface iecs_link_if;
	logic       interrupt;
	logic [7:0] address;
	logic [7:0] port_id;
	logic       write_strobe;
	logic       read_strobe;
	logic [7:0] out_port;
	logic [7:0] in_port;

	modport core
	(
		input  interrupt,
		input  in_port,
		output address,
		output port_id,
		output write_strobe,
		output read_strobe,
		output out_port
	);
	modport fabric
	(
		output interrupt,
		output in_port,
		input  address,
		input  port_id,
		input  write_strobe,
		input  read_strobe,
		input  out_port
	);
endinterface

// ### verilog/iecs_stack.sv
`timescale 1ns/1ps
module iecs_stack #(
	parameter int DEPTH = iecs_pkg::STACK_DEPTH
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       clk_en,
	// push and pop
	input  wire logic       push,
	input  wire logic       pop,
	input  wire logic [7:0] push_data,
	output logic      [7:0] top_data
);
	// refuse depths outside two to fifteen for the four-bit pointer
	if (DEPTH < 2 || DEPTH > 15)
	begin
		$error("stack depth out of range");
	end

	// ----------------------------------------
	// storage and pointer
	// ----------------------------------------
	logic [7:0] mem [0:DEPTH-1];
	logic [3:0] ptr_q;

	function automatic logic [3:0] wrap_inc(input logic [3:0] p);
		wrap_inc = (p == 4'(DEPTH - 1)) ? 4'h0 : 4'(p + 4'h1);
	endfunction

	function automatic logic [3:0] wrap_dec(input logic [3:0] p);
		wrap_dec = (p == 4'h0) ? 4'(DEPTH - 1) : 4'(p - 4'h1);
	endfunction

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			ptr_q <= 4'h0;
		else if (clk_en && push)
			ptr_q <= wrap_inc(ptr_q);
		else if (clk_en && pop)
			ptr_q <= wrap_dec(ptr_q);
	end

	always_ff @(posedge clk)
	begin
		if (clk_en && push)
			mem[ptr_q] <= push_data;
	end

	assign top_data = mem[wrap_dec(ptr_q)];
endmodule

// ### verilog/iecs_fabric.sv
`timescale 1ns/1ps
module iecs_fabric (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       clk_en,
	// user side
	input  wire logic       event_pulse,
	input  wire logic [7:0] event_cause,
	input  wire logic [1:0] ack_mode,
	output logic            pending_q,
	// link
	iecs_link_if.fabric     link
);
	logic clear;

	always_comb
	begin
		case (ack_mode)
			2'h0:    clear = link.write_strobe && link.port_id == iecs_pkg::ACK_PORT;
			2'h1:    clear = link.read_strobe && link.port_id == iecs_pkg::CAUSE_PORT;
			default: clear = link.address == iecs_pkg::VECTOR_ADDR;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			pending_q <= 1'b0;
		else if (clk_en && event_pulse)
			pending_q <= 1'b1;
		else if (clk_en && clear)
			pending_q <= 1'b0;
	end

	assign link.interrupt = pending_q;
	assign link.in_port   = event_cause;
endmodule

// ### tb/iecs_link_props.sv
`timescale 1ns/1ps
module iecs_link_props (
	// clock and reset
	input wire logic       clk,
	input wire logic       reset_n,
	// link
	input wire logic       interrupt,
	input wire logic [7:0] address,
	input wire logic [7:0] port_id,
	input wire logic       write_strobe,
	input wire logic       read_strobe,
	// fabric setup
	input wire logic [1:0] ack_mode,
	input wire logic       event_pulse
);
	// ----------------------------------------
	// link checks
	// ----------------------------------------
	slot_hold_a: assert property (
		@(posedge clk) disable iff (!reset_n) $changed(address) |=> $stable(address))
		else $error("address slot shorter than two cycles");
	vec_cause_a: assert property (
		@(posedge clk) disable iff (!reset_n) $rose(address == 8'hFF) |-> $past(interrupt))
		else $error("vector without request");
	vec_slot_a: assert property (
		@(posedge clk) disable iff (!reset_n) $rose(address == 8'hFF) |=> address == 8'hFF ##1 address != 8'hFF)
		else $error("vector slot length wrong");
	req_hold_a: assert property (
		@(posedge clk) disable iff (!reset_n) $rose(interrupt) |=> interrupt)
		else $error("request held one edge only");
	ack_clear_a: assert property (
		@(posedge clk) disable iff (!reset_n) (ack_mode == 2'h2 && $rose(address == 8'hFF)) |-> ##[1:2] !interrupt)
		else $error("request not cleared at vector");
	ack_write_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		(ack_mode == 2'h0 && write_strobe && port_id == iecs_pkg::ACK_PORT && !event_pulse) |=> !interrupt)
		else $error("request not cleared by port write");
	ack_read_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		(ack_mode == 2'h1 && read_strobe && port_id == iecs_pkg::CAUSE_PORT && !event_pulse) |=> !interrupt)
		else $error("request not cleared by port read");
	int_latency_a: assert property (
		@(posedge clk) disable iff (!reset_n) $rose(interrupt) |=> (address != 8'hFF) [*2])
		else $error("vector too soon after request");
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic       clk;
	logic       reset_n;
	logic [3:0] instr_op;
	logic [7:0] instr_arg;
	logic [3:0] instr_reg;
	logic       instr_cond_z;
	logic       event_pulse;
	logic       carry_q;
	logic       zero_q;
	logic       int_enable_q;
	logic [7:0] reg0_q;
	logic       pending_q;
	logic [3:0] rom_op[256];
	logic [7:0] rom_arg[256];
	logic [3:0] rom_reg[256];
	logic       rom_cz[256];
	logic [7:0] last_a;
	logic       last_z;
	logic [7:0] ab_a;
	logic       ab_z;
	logic [7:0] hit;
	logic [7:0] entries;
	logic [7:0] wr_data;
	logic [1:0] ack_mode;
	int         bad_count;
	int         samples_checked;

	iecs_link_if link ();
	iecs_core u_iecs_core (.clk(clk), .reset_n(reset_n), .clk_en(1'h1), .instr_op(instr_op),
		.instr_arg(instr_arg), .instr_reg(instr_reg), .instr_cond_z(instr_cond_z), .link(link),
		.carry_q(carry_q), .zero_q(zero_q), .int_enable_q(int_enable_q), .reg0_q(reg0_q));
	iecs_fabric u_iecs_fabric (.clk(clk), .reset_n(reset_n), .clk_en(1'h1), .event_pulse(event_pulse),
		.event_cause(8'h5A), .ack_mode(ack_mode), .pending_q(pending_q), .link(link));
	iecs_link_props u_iecs_link_props (.clk(clk), .reset_n(reset_n), .interrupt(link.interrupt),
		.address(link.address), .port_id(link.port_id), .write_strobe(link.write_strobe),
		.read_strobe(link.read_strobe), .ack_mode(ack_mode), .event_pulse(event_pulse));

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ----------------------------------------
	// program store and entry monitor
	// ----------------------------------------
	always @(posedge clk)
	begin
		instr_op     <= rom_op[link.address];
		instr_arg    <= rom_arg[link.address];
		instr_reg    <= rom_reg[link.address];
		instr_cond_z <= rom_cz[link.address];
		last_a       <= link.address;
		last_z       <= zero_q;
		if (reset_n && link.address == 8'hFF && last_a != 8'hFF)
		begin
			ab_a    <= last_a;
			ab_z    <= last_z;
			entries <= entries + 8'h01;
		end
		if (link.write_strobe)
			wr_data <= link.out_port;
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task check(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task put(input logic [7:0] a, input logic [3:0] op, input logic [7:0] arg, input logic [3:0] r, input logic cz);
		rom_op[a]  = op;
		rom_arg[a] = arg;
		rom_reg[a] = r;
		rom_cz[a]  = cz;
	endtask

	task wait_addr(input logic [7:0] a, input int limit);
		hit = 8'h00;
		for (int i = 0; i < limit && hit == 8'h00; i++)
		begin
			@(posedge clk);
			#1;
			hit = {7'h00, link.address === a};
		end
	endtask

	task pulse();
		@(posedge clk) event_pulse <= 1'b1;
		repeat (2) @(posedge clk);
		event_pulse <= 1'b0;
	endtask

	task ack_run(input logic [1:0] mode, input logic [7:0] n);
		@(posedge clk) ack_mode <= mode;
		pulse();
		wait_addr(8'hB0, 40);
		check("pending in service", 8'h01, {7'h00, pending_q});
		wait_addr(8'hB4, 10);
		check("pending acknowledged", 8'h00, {7'h00, pending_q});
		wait_addr(8'h12, 10);
		check("entries after ack", n, entries);
	endtask

	task do_reset();
		@(posedge clk) reset_n <= 1'b0;
		@(posedge clk);
		#1;
		check("address in reset", 8'h00, link.address);
		check("enable in reset", 8'h00, {7'h00, int_enable_q});
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
	endtask

	task summarize();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial
	begin
		reset_n = 1'b0;
		event_pulse = 1'b0;
		instr_op = 4'h0;
		instr_arg = 8'h00;
		instr_reg = 4'h0;
		instr_cond_z = 1'b0;
		last_a = 8'h00;
		entries = 8'h00;
		wr_data = 8'h00;
		ack_mode = 2'h2;
		bad_count = 0;
		samples_checked = 0;
		for (int i = 0; i < 256; i++)
			put(i[7:0], iecs_pkg::IECS_OP_NOP, 8'h00, 4'h0, 1'b0);
		put(8'h00, iecs_pkg::IECS_OP_LOAD, 8'h08, 4'h0, 1'b0);
		put(8'h04, iecs_pkg::IECS_OP_EINT, 8'h00, 4'h0, 1'b0);
		put(8'h05, iecs_pkg::IECS_OP_SUB, 8'h01, 4'h0, 1'b0);
		put(8'h06, iecs_pkg::IECS_OP_JUMP, 8'h08, 4'h0, 1'b1);
		put(8'h07, iecs_pkg::IECS_OP_JUMP, 8'h05, 4'h0, 1'b0);
		put(8'h08, iecs_pkg::IECS_OP_JUMP, 8'h10, 4'h0, 1'b0);
		put(8'h10, iecs_pkg::IECS_OP_LOAD, 8'h0F, 4'h0, 1'b0);
		put(8'h11, iecs_pkg::IECS_OP_CALL, 8'h40, 4'h0, 1'b0);
		put(8'h12, iecs_pkg::IECS_OP_JUMP, 8'h12, 4'h0, 1'b0);
		put(8'h40, iecs_pkg::IECS_OP_SUB, 8'h01, 4'h0, 1'b0);
		put(8'h41, iecs_pkg::IECS_OP_JUMP, 8'h43, 4'h0, 1'b1);
		put(8'h42, iecs_pkg::IECS_OP_CALL, 8'h40, 4'h0, 1'b0);
		put(8'h43, iecs_pkg::IECS_OP_RETURN, 8'h00, 4'h0, 1'b0);
		put(8'hB0, iecs_pkg::IECS_OP_INPUT, iecs_pkg::CAUSE_PORT, 4'h2, 1'b0);
		put(8'hB1, iecs_pkg::IECS_OP_OUTPUT, iecs_pkg::ACK_PORT, 4'h2, 1'b0);
		put(8'hB2, iecs_pkg::IECS_OP_LOAD, 8'h00, 4'h1, 1'b0);
		put(8'hB3, iecs_pkg::IECS_OP_SUB, 8'h00, 4'h1, 1'b0);
		put(8'hB4, iecs_pkg::IECS_OP_RETI, 8'h01, 4'h0, 1'b0);
		put(8'hFF, iecs_pkg::IECS_OP_JUMP, 8'hB0, 4'h0, 1'b0);
		do_reset();
		wait_addr(8'h01, 20);
		pulse();
		wait_addr(8'h05, 20);
		check("pending while disabled", 8'h01, {7'h00, pending_q});
		check("entries while disabled", 8'h00, entries);
		wait_addr(8'hB0, 40);
		check("vector taken", 8'h01, hit);
		check("enable in service", 8'h00, {7'h00, int_enable_q});
		pulse();
		wait_addr(8'hB4, 10);
		check("entries in service", 8'h01, entries);
		wait_addr(ab_a, 10);
		check("resume address", 8'h01, hit);
		check("zero restored", {7'h00, ab_z}, {7'h00, zero_q});
		check("enable on return", 8'h01, {7'h00, int_enable_q});
		check("cause written back", 8'h5A, wr_data);
		wait_addr(8'h08, 400);
		check("entries total", 8'h02, entries);
		check("sub result", 8'h00, reg0_q);
		check("sub zero flag", 8'h01, {7'h00, zero_q});
		wait_addr(8'h12, 600);
		check("return after 15 deep", 8'h01, hit);
		ack_run(2'h0, 8'h03);
		ack_run(2'h1, 8'h04);
		put(8'h10, iecs_pkg::IECS_OP_LOAD, 8'h10, 4'h0, 1'b0);
		do_reset();
		wait_addr(8'h12, 600);
		check("return after 16 deep", 8'h00, hit);
		summarize();
	end

	initial
	begin
		repeat (5000) @(posedge clk);
		bad_count++;
		summarize();
	end
endmodule
